// >>> hw/frc_ctrl.sv
// Purpose: Host controller driving a deep 9-bit FIFO (or a row of them)
// Assumes: FIFO write and read clocks are ref_clk; flag pins synchronous
// Notes: Software works through classic Wishbone registers
// How it works
// - Rewind only after <=depth writes, >=1 read
// - Enables off during rewind pulse and recovery
// - Width: shared controls, combined empty/full flags
// - Width: almost flags from any one device
// - Width: read enable may be tied low
// - Hold expansion/load pin low during reset (cascade mode leaves it undriven instead)
// - Cascade: first device first-load tied low
// - Cascade: other devices first-load held high
// - Cascade: each output feeds next input
// - Cascade: combined flags by ORing all flags
//
// The address map and the Wishbone register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "frc_params.svh"
module frc_ctrl #(
   parameter int LANES = 1,
   parameter int DEPTH = 65536,
   parameter int CNT_W = 18,
   localparam int DW = 9 * LANES
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic master_reset_in_n,
   output logic rewind_pulse_in,
   output logic fifo_write_en_n,
   output logic fifo_read_en_n,
   output logic [DW-1:0] fifo_wdata,
   input wire logic [DW-1:0] fifo_rdata,
   input wire logic [LANES-1:0] empty_flag_n,
   input wire logic [LANES-1:0] full_flag_n,
   input wire logic [LANES-1:0] almost_empty_flag_n,
   input wire logic [LANES-1:0] almost_full_flag_n,
   output logic expansion_or_load_pin,
   output logic expansion_or_load_oe,
   output logic first_load_select
);
   typedef struct packed {
      frc_pkg::frc_state_e st;
      logic ack;
      logic [31:0] dat;
      logic mrst_n;
      logic rt;
      logic wen_n;
      logic ren_n;
      logic [DW-1:0] wdata;
      logic ld_val;
      logic ld_oe;
      logic cascade;
      logic not_first;
      logic fl;
      logic [DW-1:0] rdata;
      logic rd_valid;
      logic err;
      logic [CNT_W-1:0] wr_cnt;
      logic [CNT_W-1:0] rd_cnt;
   } frc_ctrl_s;

   frc_ctrl_s q_reg;
   frc_ctrl_s q_next;
   logic tmr_load;
   logic [`FRC_TMR_W-1:0] tmr_val;
   logic tmr_done;
   logic empty_all_n;
   logic full_all_n;
   logic rt_ok;
   logic acc;
   logic wr;
   logic [5:0] idx;

   // Saturating increment keeps an overflowed count above the depth
   function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
      sat_inc = (v == '1) ? v : v + CNT_W'(1);
   endfunction

   frc_pulse_timer #(
      .W(`FRC_TMR_W)
   ) u_tmr (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .ce(ce),
      .load(tmr_load),
      .load_val(tmr_val),
      .done(tmr_done)
   );

   // Composite boundary flags: any empty device empties a wide word,
   // while a cascade only reads empty/full once every device agrees
   assign empty_all_n = q_reg.cascade ? |empty_flag_n : &empty_flag_n;
   assign full_all_n = q_reg.cascade ? |full_flag_n : &full_flag_n;
   // A cascaded chain has no rewind, so the host never asks for one
   assign rt_ok = !q_reg.cascade && (q_reg.wr_cnt <= CNT_W'(DEPTH)) &&
                  (q_reg.rd_cnt != '0);
   assign acc = wb_cyc_i && wb_stb_i && !q_reg.ack;
   assign wr = acc && wb_we_i && wb_sel_i[0];
   assign idx = wb_adr_i[7:2];

   // Sequencer first, then bus accesses that may start a new sequence
   always_comb
   begin
      q_next = q_reg;
      q_next.ack = 1'b0;
      tmr_load = 1'b0;
      tmr_val = '0;
      unique case (q_reg.st)
         frc_pkg::S_IDLE:
         begin
         end
         frc_pkg::S_MRST:
            if (tmr_done)
            begin
               q_next.mrst_n = 1'b1;
               q_next.st = frc_pkg::S_MREC;
               tmr_load = 1'b1;
               tmr_val = `FRC_TMR_W'(`FRC_RSR_CYC - 1);
            end
         frc_pkg::S_MREC:
         begin
            // Pin may rise now: hold time at release is zero
            q_next.ld_val = 1'b1;
            if (tmr_done)
               q_next.st = frc_pkg::S_IDLE;
         end
         frc_pkg::S_WR:
         begin
            q_next.wen_n = 1'b1;
            q_next.st = frc_pkg::S_IDLE;
         end
         frc_pkg::S_RD:
         begin
            q_next.ren_n = 1'b1;
            q_next.st = frc_pkg::S_CAP;
         end
         frc_pkg::S_CAP:
         begin
            // Output register of the FIFO holds the word taken last edge
            q_next.rdata = fifo_rdata;
            q_next.rd_valid = 1'b1;
            q_next.rd_cnt = sat_inc(q_reg.rd_cnt);
            q_next.st = frc_pkg::S_IDLE;
         end
         frc_pkg::S_RT:
            if (tmr_done)
            begin
               q_next.rt = 1'b0;
               q_next.st = frc_pkg::S_RTREC;
               tmr_load = 1'b1;
               tmr_val = `FRC_TMR_W'(`FRC_RTR_CYC - 1);
            end
         frc_pkg::S_RTREC:
            if (tmr_done)
               q_next.st = frc_pkg::S_IDLE;
      endcase

      // Register reads
      if (acc)
      begin
         q_next.ack = 1'b1;
         q_next.dat = '0;
         case (idx)
            `FRC_OFF_CTRL: q_next.dat[0] = (q_reg.st != frc_pkg::S_IDLE);
            `FRC_OFF_CFG:
            begin
               q_next.dat[`FRC_CFG_CASCADE] = q_reg.cascade;
               q_next.dat[`FRC_CFG_NOT_FIRST] = q_reg.not_first;
            end
            `FRC_OFF_RDATA: q_next.dat[DW-1:0] = q_reg.rdata;
            `FRC_OFF_STATUS:
            begin
               q_next.dat[`FRC_ST_BUSY] = (q_reg.st != frc_pkg::S_IDLE);
               q_next.dat[`FRC_ST_EMPTY_N] = empty_all_n;
               q_next.dat[`FRC_ST_FULL_N] = full_all_n;
               q_next.dat[`FRC_ST_AE_N] = almost_empty_flag_n[0];
               q_next.dat[`FRC_ST_AF_N] = almost_full_flag_n[0];
               q_next.dat[`FRC_ST_RD_VALID] = q_reg.rd_valid;
               q_next.dat[`FRC_ST_ERR] = q_reg.err;
               q_next.dat[`FRC_ST_RT_OK] = rt_ok;
            end
            `FRC_OFF_WCOUNT: q_next.dat[CNT_W-1:0] = q_reg.wr_cnt;
            `FRC_OFF_RCOUNT: q_next.dat[CNT_W-1:0] = q_reg.rd_cnt;
            default: q_next.dat = '0;
         endcase
      end

      // Register writes; error clear comes before any new error so set wins
      if (wr && idx == `FRC_OFF_STATUS && wb_dat_i[`FRC_ST_ERR])
         q_next.err = 1'b0;
      if (wr && idx == `FRC_OFF_CFG)
      begin
         q_next.cascade = wb_dat_i[`FRC_CFG_CASCADE];
         q_next.not_first = wb_dat_i[`FRC_CFG_NOT_FIRST];
      end
      if (wr && (idx == `FRC_OFF_CTRL || idx == `FRC_OFF_WDATA))
      begin
         if (q_reg.st != frc_pkg::S_IDLE)
            q_next.err = 1'b1;
         else if (idx == `FRC_OFF_WDATA)
         begin
            // Never pulse write enable into a full FIFO
            if (full_all_n)
            begin
               q_next.wen_n = 1'b0;
               q_next.wdata = wb_dat_i[DW-1:0];
               q_next.wr_cnt = sat_inc(q_reg.wr_cnt);
               q_next.st = frc_pkg::S_WR;
            end
            else
               q_next.err = 1'b1;
         end
         else if (wb_dat_i[`FRC_CTRL_RESET])
         begin
            // Position strap and load pin are set up with reset asserted
            q_next.mrst_n = 1'b0;
            q_next.ld_oe = !q_reg.cascade;
            q_next.ld_val = 1'b0;
            q_next.fl = q_reg.not_first;
            q_next.wr_cnt = '0;
            q_next.rd_cnt = '0;
            q_next.rd_valid = 1'b0;
            q_next.st = frc_pkg::S_MRST;
            tmr_load = 1'b1;
            tmr_val = `FRC_TMR_W'(`FRC_RS_CYC - 1);
         end
         else if (wb_dat_i[`FRC_CTRL_REWIND])
         begin
            if (rt_ok)
            begin
               q_next.rt = 1'b1;
               q_next.st = frc_pkg::S_RT;
               tmr_load = 1'b1;
               tmr_val = `FRC_TMR_W'(`FRC_PRT_CYC - 1);
            end
            else
               q_next.err = 1'b1;
         end
         else if (wb_dat_i[`FRC_CTRL_READ])
         begin
            // Width-expanded rows could tie read enable low; we pulse it
            if (empty_all_n)
            begin
               q_next.ren_n = 1'b0;
               q_next.rd_valid = 1'b0;
               q_next.st = frc_pkg::S_RD;
            end
            else
               q_next.err = 1'b1;
         end
      end
   end

   // Single state register; clock enable freezes everything
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q_reg <= '0;
         q_reg.st <= frc_pkg::S_IDLE;
         q_reg.mrst_n <= 1'b1;
         q_reg.wen_n <= 1'b1;
         q_reg.ren_n <= 1'b1;
         q_reg.ld_val <= 1'b1;
      end
      else if (ce)
         q_reg <= q_next;
   end

   assign wb_dat_o = q_reg.dat;
   assign wb_ack_o = q_reg.ack;
   assign master_reset_in_n = q_reg.mrst_n;
   assign rewind_pulse_in = q_reg.rt;
   assign fifo_write_en_n = q_reg.wen_n;
   assign fifo_read_en_n = q_reg.ren_n;
   assign fifo_wdata = q_reg.wdata;
   assign expansion_or_load_pin = q_reg.ld_val;
   assign expansion_or_load_oe = q_reg.ld_oe;
   assign first_load_select = q_reg.fl;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   AST_RT_HISTORY: assert property ($rose(q_reg.rt) |->
      ($past(q_reg.wr_cnt) <= CNT_W'(DEPTH)) && ($past(q_reg.rd_cnt) != '0))
      else $error("rewind issued without valid write/read history");
   AST_RT_QUIET: assert property (q_reg.rt |-> q_reg.wen_n && q_reg.ren_n)
      else $error("enable active during rewind pulse");
   AST_RT_RECOVERY: assert property ($fell(q_reg.rt) && ce |->
      (q_reg.wen_n && q_reg.ren_n)[*3])
      else $error("enable active inside rewind recovery");
   AST_RT_WIDTH: assert property ($rose(q_reg.rt) && ce |=> q_reg.rt)
      else $error("rewind pulse shorter than two cycles");
   AST_NO_RT_CASCADE: assert property (q_reg.rt |-> !q_reg.cascade)
      else $error("rewind driven in cascade mode");
   AST_WR_NOT_FULL: assert property ($fell(q_reg.wen_n) |-> $past(full_all_n))
      else $error("write started into full FIFO");
   AST_RD_NOT_EMPTY: assert property ($fell(q_reg.ren_n) |-> $past(empty_all_n))
      else $error("read started from empty FIFO");
   AST_LD_LOW_RESET: assert property (!q_reg.mrst_n && !q_reg.cascade |->
      q_reg.ld_oe && !q_reg.ld_val)
      else $error("load pin not held low in reset");
   AST_FL_AT_RESET: assert property ($changed(q_reg.fl) |-> !q_reg.mrst_n)
      else $error("first-load select changed outside reset");
   AST_ACK_ONE: assert property (q_reg.ack |=> !q_reg.ack)
      else $error("ack longer than one cycle");

   COV_WRITE: cover property ($fell(q_reg.wen_n));
   COV_READ: cover property (q_reg.st == frc_pkg::S_CAP);
   COV_REWIND: cover property ($fell(q_reg.rt));
   COV_RESET: cover property ($rose(q_reg.mrst_n));
endmodule
`default_nettype wire

// >>> hw/frc_params.svh
// Purpose: Constants for the rewind/expansion FIFO controller
// Assumes: ref_clk at 25 MHz
// Notes: Times in ns; cycle counts are rounded up from them
`ifndef FRC_PARAMS_SVH
`define FRC_PARAMS_SVH

`define FRC_CLK_NS 40
`define FRC_T_PRT_NS 60
`define FRC_T_RTR_NS 90
`define FRC_T_RS_NS 25
`define FRC_T_RSR_NS 15
`define FRC_PRT_CYC ((`FRC_T_PRT_NS + `FRC_CLK_NS - 1) / `FRC_CLK_NS)
`define FRC_RTR_CYC ((`FRC_T_RTR_NS + `FRC_CLK_NS - 1) / `FRC_CLK_NS)
`define FRC_RS_CYC ((`FRC_T_RS_NS + `FRC_CLK_NS - 1) / `FRC_CLK_NS)
`define FRC_RSR_CYC ((`FRC_T_RSR_NS + `FRC_CLK_NS - 1) / `FRC_CLK_NS)

`define FRC_OFF_CTRL 6'h00
`define FRC_OFF_CFG 6'h01
`define FRC_OFF_WDATA 6'h02
`define FRC_OFF_RDATA 6'h03
`define FRC_OFF_STATUS 6'h04
`define FRC_OFF_WCOUNT 6'h05
`define FRC_OFF_RCOUNT 6'h06

`define FRC_CTRL_RESET 0
`define FRC_CTRL_REWIND 1
`define FRC_CTRL_READ 2
`define FRC_CFG_CASCADE 0
`define FRC_CFG_NOT_FIRST 1
`define FRC_ST_BUSY 0
`define FRC_ST_EMPTY_N 1
`define FRC_ST_FULL_N 2
`define FRC_ST_AE_N 3
`define FRC_ST_AF_N 4
`define FRC_ST_RD_VALID 5
`define FRC_ST_ERR 6
`define FRC_ST_RT_OK 7

`define FRC_TMR_W 4
`endif

// >>> hw/frc_pkg.sv
// Purpose: Types shared by the FIFO controller
// Assumes: Nothing beyond the params header
// Notes: Sequencer states only; codes left to the tools
package frc_pkg;
   typedef enum logic [2:0] {
      S_IDLE, S_MRST, S_MREC, S_WR, S_RD, S_CAP, S_RT, S_RTREC
   } frc_state_e;
endpackage

// >>> hw/frc_pulse_timer.sv
// Purpose: Down counter that times pin pulses and recovery gaps
// Assumes: load value is cycles minus one
// Notes: done is high while the count sits at zero
`timescale 1ns/1ns
`default_nettype none
module frc_pulse_timer #(
   parameter int W = 4
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic load,
   input wire logic [W-1:0] load_val,
   output logic done
);
   typedef struct packed {
      logic [W-1:0] cnt;
   } frc_tmr_s;

   frc_tmr_s q_reg;
   frc_tmr_s q_next;

   // Reload wins over counting so back to back phases need no gap
   always_comb
   begin
      q_next = q_reg;
      if (load)
         q_next.cnt = load_val;
      else if (q_reg.cnt != '0)
         q_next.cnt = q_reg.cnt - W'(1);
   end

   // Clock enable freezes the count
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         q_reg <= '0;
      else if (ce)
         q_reg <= q_next;
   end

   assign done = (q_reg.cnt == '0);
endmodule
`default_nettype wire

// >>> testbench/frc_fifo_model.sv
// Purpose: Behavioural model of one 9-bit FIFO device on the controller's pins
// Assumes: Write and read clocks are one clock; standalone, width or lone cascaded use
// Notes: viol latches a rewind with bad write/read history or with an enable active in pulse or recovery
`timescale 1ns/1ns
`default_nettype none
module frc_fifo_model #(
   parameter int D = 16
) (
   input wire logic clk,
   input wire logic mrst_n,
   input wire logic rt,
   input wire logic wen_n,
   input wire logic ren_n,
   input wire logic [8:0] d,
   input wire logic xld,
   output logic [8:0] q,
   output logic ef_n,
   output logic ff_n,
   output logic pae_n,
   output logic paf_n,
   output logic viol
);
   logic [8:0] mem [0:D-1];
   int wp = 0;
   int rp = 0;
   int nrd = 0;
   int rec = 0;
   logic casc = 1'b0;
   logic rt_d = 1'b0;
   logic viol_r = 1'b0;
   logic [8:0] q_r = 9'h000;
   // One driver per output: the state lives in the registers above
   assign viol = viol_r;
   assign q = q_r;
   // Flags follow the pointer distance; offsets left at seven words
   assign ef_n = (wp != rp);
   assign ff_n = (wp - rp != D);
   assign pae_n = (wp - rp > 7);
   assign paf_n = (wp - rp < D - 7);
   // Pointer logic, reset sampling and rewind timing checks
   always @(posedge clk)
   begin
      rt_d <= rt;
      if (!mrst_n)
      begin
         wp <= 0;
         rp <= 0;
         nrd <= 0;
         casc <= xld;
      end
      else if (rt)
      begin
         if (!casc) rp <= 0;
         if (!rt_d && (wp > D || nrd == 0)) viol_r <= 1'b1;
         if (!wen_n || !ren_n) viol_r <= 1'b1;
         rec <= 3;
      end
      else
      begin
         if (rec > 0) rec <= rec - 1;
         if (rec > 0 && (!wen_n || !ren_n)) viol_r <= 1'b1;
         // A lone cascaded device is a ring of one: its token comes straight back
         if (!wen_n && wp - rp < D)
         begin
            mem[wp % D] <= d;
            wp <= wp + 1;
         end
         if (!ren_n && wp > rp)
         begin
            q_r <= mem[rp % D];
            rp <= rp + 1;
            nrd <= nrd + 1;
         end
      end
   end
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
// Purpose: Self-checking bench of the FIFO controller against a device model
// Assumes: DEPTH shortened to 16 in both controller and model
// Notes: Reference data kept in a bench array indexed by write count
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin n_errors++; \
   $display("MISMATCH %s exp %0h got %0h", nm, e, s); end end
module testbench;
   localparam int D = 16;
   logic ref_clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ce = 1'b1;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0, rd, wb_dat_o, seed = 32'he9a33172;
   logic wb_ack_o, mr_n, rt, wen_n, ren_n, pin, oe, fls, ef_n, ff_n, ae_n, af_n, viol;
   logic [8:0] fdo, fdi;
   logic [8:0] ref_mem [0:D-1];
   int n_errors = 0, checked = 0, cyc_n = 0, ref_w = 0, ref_r = 0;
   always #20 ref_clk = ~ref_clk;
   frc_ctrl #(.LANES(1), .DEPTH(D), .CNT_W(18)) u_frc_ctrl (.ref_clk(ref_clk),
      .rst_n(rst_n), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .master_reset_in_n(mr_n), .rewind_pulse_in(rt),
      .fifo_write_en_n(wen_n), .fifo_read_en_n(ren_n), .fifo_wdata(fdo),
      .fifo_rdata(fdi), .empty_flag_n(ef_n), .full_flag_n(ff_n),
      .almost_empty_flag_n(ae_n), .almost_full_flag_n(af_n),
      .expansion_or_load_pin(pin), .expansion_or_load_oe(oe), .first_load_select(fls));
   // Undriven pin reads as a peer's idle cascade output
   frc_fifo_model #(.D(D)) u_frc_fifo_model (.clk(ref_clk), .mrst_n(mr_n), .rt(rt),
      .wen_n(wen_n), .ren_n(ren_n), .d(fdo), .xld(oe ? pin : 1'b1), .q(fdi),
      .ef_n(ef_n), .ff_n(ff_n), .pae_n(ae_n), .paf_n(af_n), .viol(viol));
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Hang guard: whole run needs a few hundred cycles
   always @(posedge ref_clk)
   begin
      cyc_n++;
      if (cyc_n > 20000)
      begin
         n_errors++;
         finish_test();
      end
   end
   // Classic single Wishbone cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dv);
      @(posedge ref_clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'hf; wdat <= dv;
      do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      cyc <= 1'b0; stb <= 1'b0;
   endtask
   // Issue a command then poll busy with a bounded count; hold freezes ce first
   task automatic cmd(input logic [31:0] c, input int hold = 0);
      int k;
      wb(1'b1, 8'h00, c);
      if (hold > 0)
      begin
         // A frozen clock enable must keep the rewind pulse standing
         ce <= 1'b0;
         repeat (hold) @(posedge ref_clk);
         `CHK("ce freeze", 1'b1, rt)
         ce <= 1'b1;
      end
      for (k = 0; k < 40; k++)
      begin
         wb(1'b0, 8'h10, 32'h0);
         if (rd[0] === 1'b0) break;
      end
      `CHK("busy", 1'b0, rd[0])
   endtask
   task automatic put();
      seed = xs(seed);
      wb(1'b1, 8'h08, seed);
      if (ref_w - ref_r < D) ref_mem[ref_w % D] = seed[8:0];
      if (ref_w - ref_r < D) ref_w++;
   endtask
   task automatic get(input int n);
      repeat (n)
      begin
         cmd(32'h4);
         wb(1'b0, 8'h0c, 32'h0);
         `CHK("rdata", ref_mem[ref_r % D], rd[8:0])
         ref_r++;
      end
   endtask
   task automatic rewind(input int hold = 0);
      cmd(32'h2, hold);
      ref_r = 0;
   endtask
   task automatic mreset();
      cmd(32'h1);
      ref_w = 0;
      ref_r = 0;
   endtask
   initial
   begin
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      wb(1'b0, 8'h04, 32'h0);
      `CHK("cfg reset", 32'h0, rd)
      `CHK("first_load", 1'b0, fls)
      mreset();
      `CHK("load pin oe", 1'b1, oe)
      wb(1'b0, 8'h10, 32'h0);
      `CHK("rt allowed", 1'b0, rd[7])
      for (int i = 0; i <= D; i++)
      begin
         if (i == 7 || i == 8)
         begin
            wb(1'b0, 8'h10, 32'h0);
            `CHK("almost empty", i == 8, rd[3])
            `CHK("not almost full", 1'b1, rd[4])
         end
         put();
      end
      wb(1'b0, 8'h10, 32'h0);
      `CHK("full", 1'b0, rd[2])
      `CHK("almost full", 1'b0, rd[4])
      `CHK("err", 1'b1, rd[6])
      wb(1'b1, 8'h10, 32'h40);
      wb(1'b0, 8'h10, 32'h0);
      `CHK("err clr", 1'b0, rd[6])
      $display("test fill done");
      get(3);
      rewind();
      get(D);
      cmd(32'h4);
      wb(1'b0, 8'h10, 32'h0);
      `CHK("empty err", 2'b10, {rd[6], rd[1]})
      rewind(5);
      get(2);
      $display("test replay done");
      mreset();
      repeat (4) put();
      get(2);
      rewind();
      repeat (2) put();
      get(6);
      wb(1'b0, 8'h10, 32'h0);
      `CHK("empty", 1'b0, rd[1])
      $display("test append done");
      wb(1'b1, 8'h04, 32'h3);
      mreset();
      `CHK("first_load", 1'b1, fls)
      `CHK("cascade oe", 1'b0, oe)
      wb(1'b1, 8'h10, 32'h40);
      put();
      get(1);
      cmd(32'h2);
      wb(1'b0, 8'h10, 32'h0);
      `CHK("cascade rt err", 1'b1, rd[6])
      wb(1'b0, 8'h40, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      `CHK("rewind misuse", 1'b0, viol)
      $display("test cascade done");
      finish_test();
   end
endmodule
`default_nettype wire
